// ==== common/interval_timer_defs.svh ====
`ifndef INTERVAL_TIMER_DEFS_SVH
`define INTERVAL_TIMER_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADDR_INTERVAL_TIMER_CONTROL 8'hA1
`define ADDR_SUB_SECOND_COUNT 8'hA2
`define ADDR_SECONDS_COUNT 8'hA3
`define ADDR_MINUTES_COUNT 8'hA4
`define ADDR_HOURS_COUNT 8'hA5
`define ADDR_INTERVAL_COMPARE 8'hA6

// ----------------------------------------
// Control field positions
// ----------------------------------------
`define CTRL_TIMEBASE_ENABLE_BIT 0
`define CTRL_COUNT_ENABLE_BIT 1
`define CTRL_MATCH_FLAG_BIT 2
`define CTRL_SINGLE_SHOT_BIT 3
`define CTRL_SELECT_LSB 4
`define CTRL_SELECT_MSB 5

// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define CTRL_RESET 8'h00
`define COMPARE_RESET 8'h00
`define TIME_RESET 8'h00
`define SUB_SECOND_LAST 8'h7F
`define SECONDS_LAST 8'h3B
`define MINUTES_LAST 8'h3B
`define HOURS_LAST 8'h17
`define TIMER_VECTOR 16'h0053

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLOCK_PERIOD_NS 40
`define SUB_SECOND_PERIOD_NS 7812500
`define SUB_SECOND_CYCLES (`SUB_SECOND_PERIOD_NS / `CLOCK_PERIOD_NS)

`endif

// ==== common/interval_timer_pkg.sv ====
package interval_timer_pkg;

  typedef enum logic [1:0] {
    base_sub_second,
    base_seconds,
    base_minutes,
    base_hours
  } timebase_sel_t;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic [7:0] wdata;
  } sfr_req_t;

  typedef struct packed {
    logic [17:0] prescale;
    logic [7:0] sub_second;
    logic [7:0] seconds;
    logic [7:0] minutes;
    logic [7:0] hours;
    logic [7:0] interval;
    logic [7:0] compare;
    timebase_sel_t select;
    logic single_shot;
    logic match_flag;
    logic count_enable;
    logic timebase_enable;
    logic [7:0] rdata;
  } timer_state_t;

endpackage : interval_timer_pkg

// ==== rtl/interval_timer.sv ====
`timescale 1ns/1ps
`include "interval_timer_defs.svh"
// Operation
// - Timer and timebase run on the always-on crystal clock, also in power-down.
// - Two-bit select picks 1/128 s, seconds, minutes or hours update rate.
// - Interval counter steps once per step of the selected timebase stage.
// - Match flag sets when the stepped interval count equals the compare register.
// - Match flag is control bit 2; interrupt only when timer interrupt enabled.
// - Match flag stays set until software clears it.
// - In power-down with interrupt enabled, set flag wakes core to vector 0053h.
// - Single-shot mode: timeout clears the interval count enable bit.
// - Auto-reload mode: counter reloads at each timeout and keeps counting.
// - Count enable runs counter; clearing it stops and zeroes the counter.
// - Timebase enable gates timebase clock; clearing it resets timebase registers.
// - Timebase registers accept software writes while timebase enable is low.
// - Sub-second counts 0..127 each 1/128 s, wraps and steps seconds.
// - Seconds count 0..59, wrap and step minutes.
// - Minutes count 0..59, wrap and step hours.
// - Hours count 0..23, then wrap to zero.
module interval_timer
  import interval_timer_pkg::*;
#(
  parameter logic [17:0] TICK_CYCLES = 18'(`SUB_SECOND_CYCLES)
) (
  input wire logic mclk,
  input wire logic reset,
  input wire sfr_req_t sfr_req,
  input wire logic timer_irq_enable,
  input wire logic power_down,
  output logic [7:0] sfr_rdata,
  output logic timer_irq,
  output logic wake,
  output logic [15:0] wake_vector
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  localparam logic [7:0] CTRL_INIT = `CTRL_RESET;

  timer_state_t state;
  timer_state_t next_state;

  logic tick_sub;
  logic tick_sec;
  logic tick_min;
  logic tick_hour;
  logic tick_sel;
  logic [7:0] interval_inc;
  logic timeout;
  logic [7:0] ctrl_view;
  logic ctrl_wr;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_state = state;
    tick_sub = 1'b0;
    tick_sec = 1'b0;
    tick_min = 1'b0;
    tick_hour = 1'b0;
    tick_sel = 1'b0;
    ctrl_wr = sfr_req.wr && (sfr_req.addr == `ADDR_INTERVAL_TIMER_CONTROL);

    // Timebase chain; mclk stands for the crystal clock
    // Period rounds down to whole clocks, so the tick runs a few ppm fast
    if (state.timebase_enable) begin
      if (state.prescale == TICK_CYCLES - 18'h00001) begin
        next_state.prescale = 18'h00000;
        tick_sub = 1'b1;
      end else begin
        next_state.prescale = state.prescale + 18'h00001;
      end
    end else begin
      next_state.prescale = 18'h00000;
    end

    if (tick_sub) begin
      tick_sec = (state.sub_second == `SUB_SECOND_LAST);
      next_state.sub_second = tick_sec ? `TIME_RESET : state.sub_second + 8'h01;
    end

    if (tick_sec) begin
      tick_min = (state.seconds == `SECONDS_LAST);
      next_state.seconds = tick_min ? `TIME_RESET : state.seconds + 8'h01;
    end

    if (tick_min) begin
      tick_hour = (state.minutes == `MINUTES_LAST);
      next_state.minutes = tick_hour ? `TIME_RESET : state.minutes + 8'h01;
    end

    if (tick_hour) begin
      if (state.hours == `HOURS_LAST) begin
        next_state.hours = `TIME_RESET;
      end else begin
        next_state.hours = state.hours + 8'h01;
      end
    end

    // Stage overflow that clocks the interval counter
    unique case (state.select)
      base_sub_second: tick_sel = tick_sub;
      base_seconds: tick_sel = tick_sec;
      base_minutes: tick_sel = tick_min;
      base_hours: tick_sel = tick_hour;
    endcase

    // Software writes land before hardware events so that a set wins
    if (sfr_req.wr) begin
      unique case (sfr_req.addr)
        `ADDR_INTERVAL_TIMER_CONTROL: begin
          next_state.select = timebase_sel_t'(
            sfr_req.wdata[`CTRL_SELECT_MSB:`CTRL_SELECT_LSB]);
          next_state.single_shot = sfr_req.wdata[`CTRL_SINGLE_SHOT_BIT];
          next_state.match_flag = sfr_req.wdata[`CTRL_MATCH_FLAG_BIT];
          next_state.count_enable = sfr_req.wdata[`CTRL_COUNT_ENABLE_BIT];
          next_state.timebase_enable = sfr_req.wdata[`CTRL_TIMEBASE_ENABLE_BIT];
        end
        `ADDR_INTERVAL_COMPARE: next_state.compare = sfr_req.wdata;
        // Time writes only stick while the timebase is stopped
        `ADDR_SUB_SECOND_COUNT: begin
          if (!state.timebase_enable) next_state.sub_second = sfr_req.wdata;
        end
        `ADDR_SECONDS_COUNT: begin
          if (!state.timebase_enable) next_state.seconds = sfr_req.wdata;
        end
        `ADDR_MINUTES_COUNT: begin
          if (!state.timebase_enable) next_state.minutes = sfr_req.wdata;
        end
        `ADDR_HOURS_COUNT: begin
          if (!state.timebase_enable) next_state.hours = sfr_req.wdata;
        end
        default: ;
      endcase
    end

    // Falling timebase enable clears the time registers
    if (ctrl_wr && state.timebase_enable
        && !sfr_req.wdata[`CTRL_TIMEBASE_ENABLE_BIT]) begin
      next_state.prescale = 18'h00000;
      next_state.sub_second = `TIME_RESET;
      next_state.seconds = `TIME_RESET;
      next_state.minutes = `TIME_RESET;
      next_state.hours = `TIME_RESET;
    end

    // Interval counter; a compare of zero gives a full 256-tick interval
    interval_inc = state.interval + 8'h01;
    timeout = state.count_enable && tick_sel && (interval_inc == state.compare);
    if (!state.count_enable) begin
      next_state.interval = 8'h00;
    end else if (timeout) begin
      // Set after the software write above, so a same-cycle clear loses
      next_state.match_flag = 1'b1;
      next_state.interval = 8'h00;
      if (state.single_shot) begin
        next_state.count_enable = 1'b0;
      end
    end else if (tick_sel) begin
      next_state.interval = interval_inc;
    end

    // Reserved top bits are not stored and read back as zero
    ctrl_view = 8'h00;
    ctrl_view[`CTRL_TIMEBASE_ENABLE_BIT] = state.timebase_enable;
    ctrl_view[`CTRL_COUNT_ENABLE_BIT] = state.count_enable;
    ctrl_view[`CTRL_MATCH_FLAG_BIT] = state.match_flag;
    ctrl_view[`CTRL_SINGLE_SHOT_BIT] = state.single_shot;
    ctrl_view[`CTRL_SELECT_MSB:`CTRL_SELECT_LSB] = state.select;

    // Registered read data, one cycle behind the address
    unique case (sfr_req.addr)
      `ADDR_INTERVAL_TIMER_CONTROL: next_state.rdata = ctrl_view;
      `ADDR_SUB_SECOND_COUNT: next_state.rdata = state.sub_second;
      `ADDR_SECONDS_COUNT: next_state.rdata = state.seconds;
      `ADDR_MINUTES_COUNT: next_state.rdata = state.minutes;
      `ADDR_HOURS_COUNT: next_state.rdata = state.hours;
      `ADDR_INTERVAL_COMPARE: next_state.rdata = state.compare;
      default: next_state.rdata = 8'h00;
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      state.prescale <= 18'h00000;
      state.sub_second <= `TIME_RESET;
      state.seconds <= `TIME_RESET;
      state.minutes <= `TIME_RESET;
      state.hours <= `TIME_RESET;
      state.interval <= 8'h00;
      state.compare <= `COMPARE_RESET;
      state.select <= timebase_sel_t'(CTRL_INIT[`CTRL_SELECT_MSB:`CTRL_SELECT_LSB]);
      state.single_shot <= CTRL_INIT[`CTRL_SINGLE_SHOT_BIT];
      state.match_flag <= CTRL_INIT[`CTRL_MATCH_FLAG_BIT];
      state.count_enable <= CTRL_INIT[`CTRL_COUNT_ENABLE_BIT];
      state.timebase_enable <= CTRL_INIT[`CTRL_TIMEBASE_ENABLE_BIT];
      state.rdata <= 8'h00;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign sfr_rdata = state.rdata;
  assign timer_irq = state.match_flag && timer_irq_enable;
  // Wake stands as long as the flag; software must clear it
  assign wake = timer_irq && power_down;
  assign wake_vector = `TIMER_VECTOR;

endmodule : interval_timer

// ==== sim/interval_timer_properties.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Port checks
// ----------------------------------------
module interval_timer_properties
  import interval_timer_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire sfr_req_t sfr_req,
  input wire logic timer_irq_enable,
  input wire logic power_down,
  input wire logic [7:0] sfr_rdata,
  input wire logic timer_irq,
  input wire logic wake,
  input wire logic [15:0] wake_vector
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  wire ctl_wr = sfr_req.wr && sfr_req.addr == 8'hA1;
  wire idle = !sfr_req.wr;
  logic timebase_on;
  // Shadow of the timebase enable; only software ever changes it
  always_ff @(posedge mclk) begin
    if (reset) begin
      timebase_on <= 1'b0;
    end else if (ctl_wr) begin
      timebase_on <= sfr_req.wdata[0];
    end
  end
  property p_irq; timer_irq |-> timer_irq_enable; endproperty
  a_irq: assert property (p_irq) else $error("irq without enable");
  property p_wake; wake == (timer_irq && power_down) && wake_vector == 16'h0053; endproperty
  a_wake: assert property (p_wake) else $error("wake or vector wrong");
  // Only a control write or a dropped enable may take the request away
  property p_hold; timer_irq && !ctl_wr |=> timer_irq || !timer_irq_enable; endproperty
  a_hold: assert property (p_hold) else $error("flag lost");
  property p_flag_rd; timer_irq && sfr_req.addr == 8'hA1 && idle |=> sfr_rdata[2]; endproperty
  a_flag_rd: assert property (p_flag_rd) else $error("flag not in bit 2");
  property p_clear;
    (ctl_wr && timebase_on && !sfr_req.wdata[0]) ##1 idle ##1 (sfr_req.addr == 8'hA2 && idle)
      |=> sfr_rdata == 8'h00;
  endproperty
  a_clear: assert property (p_clear) else $error("time not cleared");
  property p_cmp;
    (sfr_req.wr && sfr_req.addr == 8'hA6) ##1 (sfr_req.addr == 8'hA6 && idle)
      |=> sfr_rdata == $past(sfr_req.wdata, 2);
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare readback");
  property p_sub; sfr_req.addr == 8'hA2 |=> sfr_rdata <= 8'h7F; endproperty
  a_sub: assert property (p_sub) else $error("sub-second range");
  property p_hour; sfr_req.addr == 8'hA5 |=> sfr_rdata <= 8'h17; endproperty
  a_hour: assert property (p_hour) else $error("hours range");
  cover property (wake);
  cover property ($rose(timer_irq));
  cover property (sfr_req.wr && sfr_req.addr == 8'hA5);
endmodule : interval_timer_properties

bind interval_timer interval_timer_properties u_props (.mclk(mclk), .reset(reset),
  .sfr_req(sfr_req), .timer_irq_enable(timer_irq_enable), .power_down(power_down),
  .sfr_rdata(sfr_rdata), .timer_irq(timer_irq), .wake(wake), .wake_vector(wake_vector));

// ==== sim/interval_timer_tb_top.sv ====
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_errors++; \
  $display("FAIL %0t: got %h want %h", $time, a, e); end end
// ----------------------------------------
// Bench
// ----------------------------------------
module interval_timer_tb_top
  import interval_timer_pkg::*;
;
  logic mclk, reset, irq_en, pdown, irq, wake;
  sfr_req_t req;
  logic [7:0] rdata;
  logic [15:0] vec;
  int n_errors, checked, n;
  // Short tick keeps every select reachable in a short run
  interval_timer #(.TICK_CYCLES(18'h4)) dut (.mclk(mclk), .reset(reset), .sfr_req(req),
    .timer_irq_enable(irq_en), .power_down(pdown), .sfr_rdata(rdata), .timer_irq(irq),
    .wake(wake), .wake_vector(vec));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task wr(input logic [7:0] a, input logic [7:0] d);
    req = '{a, 1'b1, d};
    @(negedge mclk) req.wr = 1'b0;
    @(negedge mclk);
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] e);
    req.addr = a;
    @(negedge mclk) `CHK(rdata, e)
  endtask : rd
  task wirq;
    n = 0;
    while (irq !== 1'b1 && n < 40) begin
      @(negedge mclk);
      n++;
    end
  endtask : wirq
  task print_verdict;
    $display("Checks %0d, errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict
  initial begin
    #400us;
    n_errors++;
    print_verdict;
  end
  initial begin
    reset = 1'b1;
    req = '0;
    irq_en = 1'b1;
    pdown = 1'b0;
    repeat (12) @(negedge mclk);
    reset = 1'b0;
    rd(8'hA1, 8'h00);
    rd(8'hA6, 8'h00);
    rd(8'hA7, 8'h00);
    wr(8'hA3, 8'h2A);
    rd(8'hA3, 8'h2A);
    for (int s = 0; s < 4; s++) begin
      wr(8'hA1, 8'h80);
      rd(8'hA2, 8'h00);
      // Preload lower stages so the chosen stage steps on the next tick
      if (s > 0) wr(8'hA2, 8'h7F);
      if (s > 1) wr(8'hA3, 8'h3B);
      if (s > 2) wr(8'hA4, 8'h3B);
      if (s > 2) wr(8'hA5, 8'h17);
      wr(8'hA6, 8'h01);
      wr(8'hA1, 8'h83 | 8'(s << 4));
      wirq;
      `CHK(irq, 1'b1)
      // Sub-second wrapped on the match tick and carried into seconds
      if (s == 1) rd(8'hA2, 8'h00);
      if (s == 1) rd(8'hA3, 8'h01);
    end
    rd(8'hA3, 8'h00);
    rd(8'hA4, 8'h00);
    rd(8'hA5, 8'h00);
    // Time writes are refused while the timebase runs
    wr(8'hA5, 8'h05);
    rd(8'hA5, 8'h00);
    pdown = 1'b1;
    @(negedge mclk) `CHK({wake, vec}, {1'b1, 16'h0053})
    irq_en = 1'b0;
    @(negedge mclk) `CHK(irq, 1'b0)
    irq_en = 1'b1;
    pdown = 1'b0;
    repeat (20) @(negedge mclk);
    `CHK(irq, 1'b1)
    wr(8'hA1, 8'h80);
    wr(8'hA6, 8'h03);
    wr(8'hA1, 8'h83);
    wirq;
    wr(8'hA1, 8'h83);
    wirq;
    // Three ticks of four clocks after the match, two spent in the clearing write
    `CHK(n, 10)
    wr(8'hA1, 8'h8B);
    wirq;
    rd(8'hA1, 8'h0D);
    wr(8'hA1, 8'h89);
    repeat (30) @(negedge mclk);
    `CHK(irq, 1'b0)
    print_verdict;
  end
endmodule : interval_timer_tb_top
